// ---- src/ltf_filter.sv ----
// minimum pulse width filter
`timescale 1ns/100ps
module ltf_filter
   import ltf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [15:0] min_cyc,
   input wire logic trig_in,
   output logic trig_out
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   assign cnt_d = !trig_in ? 16'h0000 : (cnt_q == 16'hFFFF ? cnt_q : cnt_q + 16'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   // [R11] zero width is the off position; [R17] pass once wider than min_cyc
   assign trig_out = (min_cyc == 16'h0000) ? trig_in : (trig_in && cnt_q >= min_cyc);
endmodule // ltf_filter

// ---- src/ltf_pkg.sv ----
// shared constants for the logic trigger recogniser
package ltf_pkg;
   localparam int LTF_NCH = 4;
   // register offsets (byte addresses)
   localparam logic [7:0] LTF_ADR_CTRL = 8'h00;
   localparam logic [7:0] LTF_ADR_TERMA = 8'h04;
   localparam logic [7:0] LTF_ADR_TERMB = 8'h08;
   localparam logic [7:0] LTF_ADR_FILT = 8'h0C;
   localparam logic [7:0] LTF_ADR_LEVEL = 8'h10;
   localparam logic [7:0] LTF_ADR_CMD = 8'h14;
   localparam logic [7:0] LTF_ADR_STAT = 8'h18;
   localparam logic [7:0] LTF_ADR_IND = 8'h1C;
   // ctrl fields
   localparam int LTF_CTRL_PROGRAM_SELECT = 0;
   localparam int LTF_CTRL_SEQ = 1;
   localparam int LTF_CTRL_BEN = 2;
   localparam int LTF_CTRL_SELB = 3;
   // term fields: [3:0] member, [4] invert, [5] edge
   localparam int LTF_TERM_INV = 4;
   localparam int LTF_TERM_EDGE = 5;
   // command register bits (write-one pulses)
   localparam int LTF_CMD_CLEAR = 0;
   localparam int LTF_CMD_NOT = 1;
   localparam int LTF_CMD_EDGE = 2;
   localparam int LTF_CMD_PRESET = 3;
   localparam int LTF_CMD_CH0 = 4;
   // switching level in millivolts, deflection in volts per division
   localparam logic [15:0] LTF_LEVEL_DEFAULT_MV = 16'h0578;
   localparam logic [7:0] LTF_DEFL_DEFAULT_V = 8'h05;
   localparam logic [15:0] LTF_FILT_RESET = 16'h0000;
   // indicator flash half period
   localparam int LTF_FLASH_MS = 250;
   localparam int LTF_CLK_MHZ = 250;
   localparam int LTF_FLASH_CYC = LTF_FLASH_MS * 1000 * LTF_CLK_MHZ;
   localparam logic [31:0] LTF_UNMAPPED = 32'h0000_0000;
endpackage

// ---- src/ltf_term.sv ----
// one A or B term: AND of member channels, inversion, edge qualification
`timescale 1ns/100ps
module ltf_term
   import ltf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [LTF_NCH-1:0] high_in,
   input wire logic [LTF_NCH-1:0] member,
   input wire logic invert,
   input wire logic edge_en,
   output logic term_out
);
   logic [LTF_NCH-1:0] in_prev_q;
   logic now_w;
   logic before_w;
   // an inverted term wants every member low, so one member gives its falling edge
   function automatic logic term_level(input logic [LTF_NCH-1:0] lvl, input logic [LTF_NCH-1:0] mem,
                                       input logic inv);
      logic [LTF_NCH-1:0] act;
      act = inv ? ~lvl : lvl;
      return (mem != 4'h0) && ((act & mem) == mem);
   endfunction
   // [R1] and across members
   assign now_w = term_level(high_in, member, invert);
   // [R5] last inputs judged with today's settings, so rewriting a term makes no false edge
   assign before_w = term_level(in_prev_q, member, invert);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_prev_q <= 4'h0;
      end else begin
         in_prev_q <= high_in;
      end
   end
   // [R4] one-cycle pulse at the rising transition; [R8] single channel falling
   assign term_out = edge_en ? (now_w & ~before_w) : now_w;
endmodule // ltf_term

// ---- src/ltf_top.sv ----
// logic trigger recogniser with wishbone register access
// How it works
// [R1] the trigger is high only while every channel in the AND term meets its active level together.
// [R2] a red channel term is active when the input is above the switching level.
// [R3] edge mode on a term makes that term's channel indicators flash; the indicators here show term A only.
// [R4] edge mode on a plain term gives a one-cycle pulse at the rising transition.
// [R5] invert plus edge gives the pulse at the falling transition.
// [R6] invert and edge each toggle per press, and two presses undo one.
// [R7] no trigger leaves the block while the programmed condition is false.
// [R8] invert, edge and one channel together mean that channel's falling edge.
// [R9] without sequencing the trigger follows term B alone; here that needs the B enable bit, and with it clear the trigger follows term A.
// [R10] sequenced mode fires on B's first leading edge after A, then re-arms.
// [R11] the filter drops pulses narrower than its setting, and zero turns it off.
// [R12] a channel whose level is under the switching level is not seen high.
// [R13] the logic family preset restores 1.4 V switching level and 5 V per division.
// [R14] the program lamp is green in trigger programming mode, where buttons edit terms.
// [R15] a green channel term is active when the input is below the switching level.
// [R16] clear removes all channel terms and turns all trigger indicators off.
// [R17] the filter width is a minimum count of clock cycles.
`timescale 1ns/100ps
module ltf_top
   import ltf_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [LTF_NCH-1:0] INPUT_ABOVE_LEVEL,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic TRIGGER_OUT,
   output logic TRIGGER_MONITOR_TRACE,
   output logic PROGRAM_SELECT_GREEN,
   output logic [LTF_NCH-1:0] IND_RED,
   output logic [LTF_NCH-1:0] IND_GREEN,
   output logic [15:0] SWITCHING_LEVEL_MV,
   output logic [7:0] DEFLECTION_V
);
   logic [3:0] ctrl_q;
   logic [3:0] ctrl_d;
   logic [5:0] terma_q;
   logic [5:0] terma_d;
   logic [5:0] termb_q;
   logic [5:0] termb_d;
   logic [15:0] filt_q;
   logic [15:0] filt_d;
   logic [15:0] level_q;
   logic [15:0] level_d;
   logic [7:0] defl_q;
   logic [7:0] defl_d;
   logic armed_q;
   logic armed_d;
   logic b_prev_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [31:0] rdata_w;
   logic trig_q;
   logic [LTF_NCH-1:0] red_q;
   logic [LTF_NCH-1:0] green_q;
   logic [27:0] flash_cnt_q;
   logic flash_q;
   logic req_w;
   logic wr_w;
   logic term_a_w;
   logic term_b_w;
   logic raw_trig_w;
   logic filt_trig_w;
   logic [5:0] edit_w;
   logic [5:0] edited_w;
   logic [7:0] cmd_w;
   logic cmd_wr_w;
   logic [LTF_NCH-1:0] red_d;
   logic [LTF_NCH-1:0] green_d;
   logic hit_ctrl_w;
   logic hit_terma_w;
   logic hit_termb_w;
   logic hit_filt_w;
   logic hit_level_w;
   logic hit_cmd_w;
   logic hit_stat_w;
   logic hit_ind_w;
   logic cmd_clear_w;
   logic cmd_not_w;
   logic cmd_edge_w;
   logic cmd_preset_w;
   logic [LTF_NCH-1:0] cmd_chan_w;
   logic fire_w;
   logic flash_wrap_w;

   // byte-lane merge of a write into a 32-bit field
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
      return adr == reg_adr;
   endfunction

   // one decode per register, shared by the write path and the read mux
   assign hit_ctrl_w = hit(WB_ADR_I, LTF_ADR_CTRL);
   assign hit_terma_w = hit(WB_ADR_I, LTF_ADR_TERMA);
   assign hit_termb_w = hit(WB_ADR_I, LTF_ADR_TERMB);
   assign hit_filt_w = hit(WB_ADR_I, LTF_ADR_FILT);
   assign hit_level_w = hit(WB_ADR_I, LTF_ADR_LEVEL);
   assign hit_cmd_w = hit(WB_ADR_I, LTF_ADR_CMD);
   assign hit_stat_w = hit(WB_ADR_I, LTF_ADR_STAT);
   assign hit_ind_w = hit(WB_ADR_I, LTF_ADR_IND);

   assign req_w = WB_CYC_I && WB_STB_I && !ack_q;
   // writes land at the edge where the master sees ack, not one edge earlier
   assign wr_w = WB_CYC_I && WB_STB_I && ack_q && WB_WE_I;
   assign cmd_wr_w = wr_w && hit_cmd_w && WB_SEL_I[0];
   assign cmd_w = cmd_wr_w ? WB_DAT_I[7:0] : 8'h00;
   assign cmd_clear_w = cmd_w[LTF_CMD_CLEAR];
   assign cmd_not_w = cmd_w[LTF_CMD_NOT];
   assign cmd_edge_w = cmd_w[LTF_CMD_EDGE];
   assign cmd_preset_w = cmd_w[LTF_CMD_PRESET];
   assign cmd_chan_w = cmd_w[LTF_CMD_CH0 +: LTF_NCH];

   // [R14] button commands edit the selected term only in programming mode
   assign edit_w = ctrl_q[LTF_CTRL_SELB] ? termb_q : terma_q;
   // [R6] each press toggles invert or edge
   assign edited_w = {edit_w[LTF_TERM_EDGE] ^ cmd_edge_w,
                      edit_w[LTF_TERM_INV] ^ cmd_not_w,
                      edit_w[3:0] | cmd_chan_w};

   always_comb begin
      ctrl_d = ctrl_q;
      terma_d = terma_q;
      termb_d = termb_q;
      filt_d = filt_q;
      level_d = level_q;
      defl_d = defl_q;
      if (wr_w && hit_ctrl_w) begin
         ctrl_d = 4'(wmerge({28'h0, ctrl_q}, WB_DAT_I, WB_SEL_I));
      end
      if (wr_w && hit_terma_w) begin
         terma_d = 6'(wmerge({26'h0, terma_q}, WB_DAT_I, WB_SEL_I));
      end
      if (wr_w && hit_termb_w) begin
         termb_d = 6'(wmerge({26'h0, termb_q}, WB_DAT_I, WB_SEL_I));
      end
      if (wr_w && hit_filt_w) begin
         filt_d = 16'(wmerge({16'h0, filt_q}, WB_DAT_I, WB_SEL_I));
      end
      if (wr_w && hit_level_w) begin
         level_d = 16'(wmerge({16'h0, level_q}, WB_DAT_I, WB_SEL_I));
         defl_d = 8'(wmerge({8'h00, defl_q, level_q}, WB_DAT_I, WB_SEL_I) >> 16);
      end
      if (ctrl_q[LTF_CTRL_PROGRAM_SELECT] && cmd_wr_w) begin
         if (ctrl_q[LTF_CTRL_SELB]) begin
            termb_d = edited_w;
         end else begin
            terma_d = edited_w;
         end
      end
      // [R16] clear drops every term
      if (ctrl_q[LTF_CTRL_PROGRAM_SELECT] && cmd_clear_w) begin
         terma_d = 6'h00;
         termb_d = 6'h00;
      end
      // [R13] preset restores level and deflection
      if (cmd_preset_w) begin
         level_d = LTF_LEVEL_DEFAULT_MV;
         defl_d = LTF_DEFL_DEFAULT_V;
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_q <= 4'h0;
         terma_q <= 6'h00;
         termb_q <= 6'h00;
         filt_q <= LTF_FILT_RESET;
         level_q <= LTF_LEVEL_DEFAULT_MV;
         defl_q <= LTF_DEFL_DEFAULT_V;
      end else begin
         ctrl_q <= ctrl_d;
         terma_q <= terma_d;
         termb_q <= termb_d;
         filt_q <= filt_d;
         level_q <= level_d;
         defl_q <= defl_d;
      end
   end

   // [R2] [R12] [R15] the comparator result arrives as INPUT_ABOVE_LEVEL; invert selects below
   ltf_term u_term_a (
      .clk(CLK),
      .rst_n(RESETN),
      .high_in(INPUT_ABOVE_LEVEL),
      .member(terma_q[3:0]),
      .invert(terma_q[LTF_TERM_INV]),
      .edge_en(terma_q[LTF_TERM_EDGE]),
      .term_out(term_a_w)
   );

   ltf_term u_term_b (
      .clk(CLK),
      .rst_n(RESETN),
      .high_in(INPUT_ABOVE_LEVEL),
      .member(termb_q[3:0]),
      .invert(termb_q[LTF_TERM_INV]),
      .edge_en(termb_q[LTF_TERM_EDGE]),
      .term_out(term_b_w)
   );

   // [R10] arm on A, fire on B's leading edge, then disarm; firing beats a fresh A
   assign fire_w = term_b_w && !b_prev_q && armed_q;
   assign armed_d = fire_w ? 1'b0 : (armed_q | term_a_w);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         armed_q <= 1'b0;
         b_prev_q <= 1'b0;
      end else begin
         armed_q <= ctrl_q[LTF_CTRL_SEQ] ? armed_d : 1'b0;
         b_prev_q <= term_b_w;
      end
   end

   // [R9] term A when B is disabled, plain B when enabled and unsequenced; [R7] nothing when no term matches
   assign raw_trig_w = !ctrl_q[LTF_CTRL_BEN] ? term_a_w :
                       ctrl_q[LTF_CTRL_SEQ] ? fire_w : term_b_w;

   ltf_filter u_filter (
      .clk(CLK),
      .rst_n(RESETN),
      .min_cyc(filt_q),
      .trig_in(raw_trig_w),
      .trig_out(filt_trig_w)
   );

   // [R3] flash clock for edge-mode indicators; a quarter-second half period is far beyond a short test
   assign flash_wrap_w = flash_cnt_q == 28'(LTF_FLASH_CYC - 1);
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         flash_cnt_q <= 28'h0000000;
         flash_q <= 1'b0;
      end else if (flash_wrap_w) begin
         flash_cnt_q <= 28'h0000000;
         flash_q <= !flash_q;
      end else begin
         flash_cnt_q <= flash_cnt_q + 28'h0000001;
      end
   end

   // [R3] [R16] indicators of term A members: red high, green low, dark when not a member
   generate
      for (genvar c = 0; c < LTF_NCH; c++) begin : g_ind
         logic on_w;
         assign on_w = terma_q[c] && !(terma_q[LTF_TERM_EDGE] && flash_q);
         assign red_d[c] = on_w && !terma_q[LTF_TERM_INV];
         assign green_d[c] = on_w && terma_q[LTF_TERM_INV];
      end
   endgenerate

   assign rdata_w = hit_ctrl_w ? {28'h0, ctrl_q} :
                    hit_terma_w ? {26'h0, terma_q} :
                    hit_termb_w ? {26'h0, termb_q} :
                    hit_filt_w ? {16'h0, filt_q} :
                    hit_level_w ? {8'h0, defl_q, level_q} :
                    hit_stat_w ? {28'h0, armed_q, term_b_w, term_a_w, trig_q} :
                    hit_ind_w ? {24'h0, green_q, red_q} : LTF_UNMAPPED;

   // read data is caught at the taking edge and shown alongside ack
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         trig_q <= 1'b0;
         red_q <= 4'h0;
         green_q <= 4'h0;
      end else begin
         ack_q <= req_w;
         dat_q <= req_w ? rdata_w : dat_q;
         trig_q <= filt_trig_w;
         red_q <= red_d;
         green_q <= green_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
   assign TRIGGER_OUT = trig_q;
   // the monitor trace mirrors exactly what the time base receives
   assign TRIGGER_MONITOR_TRACE = trig_q;
   assign PROGRAM_SELECT_GREEN = ctrl_q[LTF_CTRL_PROGRAM_SELECT];
   assign IND_RED = red_q;
   assign IND_GREEN = green_q;
   assign SWITCHING_LEVEL_MV = level_q;
   assign DEFLECTION_V = defl_q;
endmodule // ltf_top

// ---- test/ltf_chk.sv ----
// port checker for the logic trigger recogniser
`timescale 1ns/100ps
module ltf_chk
   import ltf_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic TRIGGER_OUT,
   input wire logic TRIGGER_MONITOR_TRACE,
   input wire logic PROGRAM_SELECT_GREEN,
   input wire logic [LTF_NCH-1:0] IND_RED,
   input wire logic [LTF_NCH-1:0] IND_GREEN,
   input wire logic [15:0] SWITCHING_LEVEL_MV,
   input wire logic [7:0] DEFLECTION_V
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   wire req = WB_CYC_I & WB_STB_I & !WB_ACK_O;
   wire wr = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I;
   wire unmap = WB_ADR_I > 8'h1C || WB_ADR_I[1:0] != 2'h0;
   ack_answer_a: assert property (req |=> WB_ACK_O) else $error("ack missing");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   mon_copy_a: assert property (TRIGGER_MONITOR_TRACE == TRIGGER_OUT) else $error("monitor differs");
   lamp_cause_a: assert property ($rose(PROGRAM_SELECT_GREEN) |-> $past(wr) && $past(WB_ADR_I) == LTF_ADR_CTRL)
      else $error("lamp lit without ctrl write");
   level_cause_a: assert property ($changed(SWITCHING_LEVEL_MV) |-> $past(wr)) else $error("level moved");
   defl_cause_a: assert property ($changed(DEFLECTION_V) |-> $past(wr)) else $error("deflection moved");
   unmap_zero_a: assert property (WB_ACK_O && $past(req && !WB_WE_I && unmap) |-> WB_DAT_O == 32'h0)
      else $error("unmapped read not zero");
   cmd_read_a: assert property (WB_ACK_O && $past(req && !WB_WE_I && WB_ADR_I == LTF_ADR_CMD) |-> WB_DAT_O == 32'h0)
      else $error("command read not zero");
   ind_excl_a: assert property ((IND_RED & IND_GREEN) == 4'h0) else $error("red and green together");
   cover property (wr);
   cover property ($rose(TRIGGER_OUT));
   cover property ($rose(PROGRAM_SELECT_GREEN));
endmodule // ltf_chk

// ---- test/ltf_timebase.sv ----
// time-base model: counts trigger events it receives
`timescale 1ns/100ps
module ltf_timebase (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic trig,
   output int n_trig
);
   logic last_q;
   // a held trigger starts one sweep only, so count rising edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_q <= 1'b0;
         n_trig <= 0;
      end else begin
         last_q <= trig;
         if (trig && !last_q) n_trig <= n_trig + 1;
      end
   end
endmodule // ltf_timebase

// ---- test/tb.sv ----
// self-checking bench for the logic trigger recogniser
`timescale 1ns/100ps
module tb;
   import ltf_pkg::*;
   logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
   logic [3:0] inp = 4'h0, v;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q;
   wire [31:0] dat_o;
   wire ack, trig, mon, psg;
   wire [3:0] ind_r, ind_g;
   wire [15:0] lvl;
   wire [7:0] defl;
   int n_mismatch = 0, comparisons = 0, n_trig, c;
   logic [3:0] sq [8] = '{4'h8, 4'h0, 4'h1, 4'h0, 4'h8, 4'h0, 4'h8, 4'h0};
   int se [8] = '{0, 0, 0, 0, 1, 1, 1, 1};
   always #2 clk = ~clk;
   ltf_top dut_u (.CLK(clk), .RESETN(rst_n), .INPUT_ABOVE_LEVEL(inp), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .TRIGGER_OUT(trig), .TRIGGER_MONITOR_TRACE(mon), .PROGRAM_SELECT_GREEN(psg), .IND_RED(ind_r),
      .IND_GREEN(ind_g), .SWITCHING_LEVEL_MV(lvl), .DEFLECTION_V(defl));
   ltf_timebase tmb_u (.clk(clk), .rst_n(rst_n), .trig(trig), .n_trig(n_trig));
   function logic f_and(input logic [3:0] i, input logic [3:0] m);
      return m != 4'h0 && (i & m) == m;
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task test_done;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      do begin @(posedge clk); end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 0; stb <= 0;
      chk(ack, 1'b1);
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task drv(input logic [3:0] x);
      @(posedge clk) inp <= x;
   endtask
   task edg(input logic [31:0] t, input int r, input int f);
      wb(1, LTF_ADR_TERMA, t); drv(4'h0); tick(3); c = n_trig;
      drv(4'h1); tick(4); chk(n_trig - c, r); chk(trig, 1'b0);
      c = n_trig; drv(4'h0); tick(4); chk(n_trig - c, f); chk(trig, 1'b0);
   endtask
   task pls(input int w, input int e);
      c = n_trig; drv(4'h1); repeat (w) @(posedge clk); inp <= 4'h0; tick(8);
      chk(n_trig - c, e);
   endtask
   initial begin
      void'($urandom(88));
      repeat (10) @(posedge clk);
      rst_n <= 1;
      tick(1);
      chk(lvl, LTF_LEVEL_DEFAULT_MV); chk(defl, LTF_DEFL_DEFAULT_V); chk(trig, 1'b0);
      wb(1, LTF_ADR_CTRL, 32'h1); tick(1); chk(psg, 1'b1);
      wb(1, 8'h24, 32'hFFFFFFFF); wb(0, 8'h24, 0); chk(q, 32'h0);
      wb(1, LTF_ADR_TERMA, 32'h9); tick(1); chk(ind_r, 4'h9); chk(ind_g, 4'h0);
      for (int i = 0; i < 26; i++) begin
         v = i < 16 ? i[3:0] : 4'($urandom);
         drv(v); tick(2); chk(trig, f_and(v, 4'h9));
      end
      wb(1, LTF_ADR_TERMA, 32'h11); tick(1); chk(ind_g, 4'h1); chk(ind_r, 4'h0);
      drv(4'h0); tick(2); chk(trig, 1'b1); drv(4'h1); tick(2); chk(trig, 1'b0);
      wb(1, LTF_ADR_CMD, 32'h6); wb(0, LTF_ADR_TERMA, 0); chk(q, 32'h21);
      wb(1, LTF_ADR_CMD, 32'h6); wb(0, LTF_ADR_TERMA, 0); chk(q, 32'h11);
      edg(32'h21, 1, 0);
      edg(32'h31, 0, 1);
      wb(1, LTF_ADR_CMD, 32'h1); wb(0, LTF_ADR_TERMA, 0); chk(q, 32'h0);
      tick(1); chk(ind_r, 4'h0); chk(ind_g, 4'h0);
      drv(4'hF); tick(3); chk(trig, 1'b0);
      wb(1, LTF_ADR_TERMA, 32'h1); wb(1, LTF_ADR_TERMB, 32'h8); wb(1, LTF_ADR_CTRL, 32'h5);
      for (int i = 0; i < 12; i++) begin
         v = 4'($urandom);
         drv(v); tick(2); chk(trig, v[3]); chk(mon, v[3]);
      end
      drv(4'h0); wb(1, LTF_ADR_CTRL, 32'h7); tick(3); c = n_trig;
      for (int i = 0; i < 8; i++) begin
         drv(sq[i]); tick(3); chk(n_trig - c, se[i]);
      end
      wb(1, LTF_ADR_CTRL, 32'h1); wb(1, LTF_ADR_FILT, 32'h3); drv(4'h0); tick(3);
      pls(3, 0);
      pls(6, 1);
      wb(1, LTF_ADR_FILT, 32'h0);
      pls(1, 1);
      wb(1, LTF_ADR_LEVEL, 32'h000A0800); tick(1); chk(lvl, 16'h0800); chk(defl, 8'h0A);
      wb(1, LTF_ADR_CTRL, 32'h0); wb(1, LTF_ADR_CMD, 32'h2E); tick(1);
      chk(lvl, LTF_LEVEL_DEFAULT_MV); chk(defl, LTF_DEFL_DEFAULT_V); chk(psg, 1'b0);
      wb(0, LTF_ADR_TERMA, 0); chk(q, 32'h1);
      test_done;
   end
   // the run needs a few hundred cycles; this bound leaves ample margin
   initial begin
      #40000;
      n_mismatch++;
      test_done;
   end
endmodule // tb
bind ltf_top ltf_chk chk_u (.CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O,
   .TRIGGER_OUT, .TRIGGER_MONITOR_TRACE, .PROGRAM_SELECT_GREEN, .IND_RED, .IND_GREEN, .SWITCHING_LEVEL_MV,
   .DEFLECTION_V);
